// ===== src/lcdi_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcdi_defs.svh"

module lcdi_decoder #(
    parameter int CLEAR_CYC = `LCDI_CLEAR_CYC,
    parameter int BLINK_CYC = `LCDI_BLINK_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_register_select,
    input  wire logic       i_wr_stb,
    input  wire logic       i_rd_stb,
    input  wire logic [7:0] i_wr_data,
    output logic      [7:0] o_rd_data,
    output logic            o_busy_indication,
    output logic            o_display_on,
    output logic            o_cursor_on,
    output logic            o_blink_on,
    output logic            o_blink_phase,
    output logic      [3:0] o_cursor_row,
    output logic      [6:0] o_cursor_addr,
    output logic      [6:0] o_display_shift,
    output logic            o_two_line,
    output logic            o_font_large,
    output logic            o_data_length,
    output logic            o_glyph_sel
);

    // ****************************************
    // Helpers
    // ****************************************

    // Next counter value for one step up or down
    function automatic logic [6:0] ac_step(input logic [6:0] ac, input logic up,
                                           input logic glyph, input logic two);
        logic [6:0] r;
        r = ac;
        if (glyph)
            r = {1'b0, up ? ac[5:0] + 6'h01 : ac[5:0] - 6'h01};
        else if (two)
        begin
            // Line ends wrap to the other line
            if (up)
                r = (ac == `LCDI_LINE1_LAST) ? `LCDI_LINE2_BASE :
                    (ac == `LCDI_LINE2_LAST) ? 7'h00 : ac + 7'h01;
            else
                r = (ac == 7'h00) ? `LCDI_LINE2_LAST :
                    (ac == `LCDI_LINE2_BASE) ? `LCDI_LINE1_LAST : ac - 7'h01;
        end
        else if (up)
            r = (ac == `LCDI_ONE_LAST) ? 7'h00 : ac + 7'h01;
        else
            r = (ac == 7'h00) ? `LCDI_ONE_LAST : ac - 7'h01;
        return r;
    endfunction

    // Display address to array index; second line packs after the first
    function automatic logic [6:0] dram_idx(input logic [6:0] ac, input logic two);
        return (two && ac[6]) ? ac - `LCDI_LINE2_BASE + `LCDI_LINE_LEN : ac;
    endfunction

    // Next display shift offset, modulo the line length
    function automatic logic [6:0] sh_step(input logic [6:0] s, input logic left,
                                           input logic two);
        logic [6:0] len;
        len = two ? `LCDI_LINE_LEN : 7'(`LCDI_DRAM_DEPTH);
        if (left)
            return (s == len - 7'h01) ? 7'h00 : s + 7'h01;
        else
            return (s == 7'h00) ? len - 7'h01 : s - 7'h01;
    endfunction

    localparam logic [16:0] CLR_N  = 17'(CLEAR_CYC);
    localparam logic [16:0] SHRT_N = 17'(`LCDI_SHORT_CYC);
    localparam logic [16:0] DATA_N = 17'(`LCDI_DATA_CYC);

    // ****************************************
    // State
    // ****************************************
    lcdi_pkg::lcdi_state_e st_q;        // Execution state
    logic [16:0]           cnt_q;       // Busy cycles left
    logic [6:0]            fill_q;      // Clear fill index
    logic [6:0]            ac_q;        // Address counter
    logic [6:0]            shift_q;     // Display shift offset
    logic                  glyph_q;     // Data goes to glyph RAM
    logic                  id_q;        // Increment direction
    logic                  sh_q;        // Entry shift
    logic                  dl_q;        // Data length, 1 = 8 bit
    logic                  n_q;         // Two lines
    logic                  f_q;         // Large font
    logic                  d_q;         // Display on
    logic                  c_q;         // Cursor on
    logic                  b_q;         // Blink on
    logic                  step_q;      // Counter step pending
    logic                  shpend_q;    // Display shift pending
    logic                  stale_q;     // Next data read is stale
    logic                  nib_q;       // Second nibble expected
    logic [3:0]            hi_q;        // First nibble of a write
    logic [3:0]            lo_q;        // Low nibble of a read
    logic [7:0]            buf_q;       // Read-ahead buffer
    logic [24:0]           bcnt_q;      // Blink interval count
    logic                  bph_q;       // Blink phase

    // Local storage
    logic [7:0] dram [`LCDI_DRAM_DEPTH];
    logic [7:0] cram [`LCDI_CRAM_DEPTH];

    // ****************************************
    // Byte assembly and decode
    // ****************************************
    logic       busy;                   // Instruction in progress
    logic       wr_go;                  // Whole byte written
    logic       rd_go;                  // Whole byte read
    logic [7:0] byte_w;                 // Assembled write byte
    logic [7:0] stat_w;                 // Status word
    logic [7:0] ram_w;                  // RAM byte at counter
    logic [6:0] idx_w;                  // Display array index
    logic       ins, dwr, drd;          // Accepted operations

    assign busy   = (st_q != lcdi_pkg::LCDI_IDLE);
    assign byte_w = dl_q ? i_wr_data : {hi_q, i_wr_data[7:4]};
    assign wr_go  = i_wr_stb && (dl_q || nib_q);
    assign rd_go  = i_rd_stb && (dl_q || !nib_q);
    assign stat_w = {busy, ac_q};
    assign idx_w  = dram_idx(ac_q, n_q);
    assign ram_w  = glyph_q ? cram[ac_q[5:0]] :
                    (idx_w < 7'(`LCDI_DRAM_DEPTH)) ? dram[idx_w] : `LCDI_SPACE;
    // Busy device ignores instructions and data; status read always works
    assign ins    = wr_go && !i_register_select && !busy;
    assign dwr    = wr_go && i_register_select && !busy;
    assign drd    = rd_go && i_register_select && !busy;

    logic is_clr, is_home, is_ent, is_dsp, is_shf, is_fun, is_cga, is_dda;
    assign is_dda  = ins && byte_w[7];
    assign is_cga  = ins && byte_w[7:6] == 2'b01;
    assign is_fun  = ins && byte_w[7:5] == 3'b001;
    assign is_shf  = ins && byte_w[7:4] == 4'b0001;
    assign is_dsp  = ins && byte_w[7:3] == 5'b00001;
    assign is_ent  = ins && byte_w[7:2] == 6'b000001;
    assign is_home = ins && byte_w[7:1] == 7'b0000001;
    assign is_clr  = ins && byte_w == 8'h01;

    // ****************************************
    // Nibble pairing in four-bit mode
    // ****************************************
    // Phase flips on every strobe; reads and writes share it
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            nib_q <= 1'b0;
            hi_q  <= 4'h0;
        end
        else if (!dl_q && (i_wr_stb || i_rd_stb))
        begin
            nib_q <= !nib_q;
            if (i_wr_stb && !nib_q)
                hi_q <= i_wr_data[7:4];
        end
        else if (dl_q)
            nib_q <= 1'b0;
    end

    // ****************************************
    // Read data path
    // ****************************************
    // Answer stands one cycle after the strobe; high nibble first
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_rd_data <= 8'h00;
            lo_q      <= 4'h0;
            buf_q     <= 8'h00;
        end
        else if (i_rd_stb)
        begin
            if (!dl_q && nib_q)
                o_rd_data <= {lo_q, 4'h0};
            else
            begin
                logic [7:0] v;
                v = !i_register_select ? stat_w :
                    busy ? buf_q : (stale_q ? buf_q : ram_w);
                o_rd_data <= dl_q ? v : {v[7:4], 4'h0};
                lo_q      <= v[3:0];
            end
            if (drd)
                buf_q <= ram_w;
        end
    end

    // ****************************************
    // RAM writes and clear fill
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (st_q == lcdi_pkg::LCDI_FILL)
            dram[fill_q] <= `LCDI_SPACE;
        else if (dwr && glyph_q)
            cram[ac_q[5:0]] <= byte_w;
        else if (dwr && idx_w < 7'(`LCDI_DRAM_DEPTH))
            dram[idx_w] <= byte_w;
    end

    // ****************************************
    // Execution timer and state
    // ****************************************
    // Each accepted byte loads its execution time
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            st_q   <= lcdi_pkg::LCDI_IDLE;
            cnt_q  <= 17'h0;
            fill_q <= 7'h0;
        end
        else
        begin
            unique case (st_q)
                lcdi_pkg::LCDI_IDLE:
                begin
                    if (is_clr)
                    begin
                        st_q   <= lcdi_pkg::LCDI_FILL;
                        cnt_q  <= CLR_N - 17'h1;
                        fill_q <= 7'h0;
                    end
                    else if (is_home)
                    begin
                        st_q  <= lcdi_pkg::LCDI_EXEC;
                        cnt_q <= CLR_N - 17'h1;
                    end
                    else if (ins)
                    begin
                        st_q  <= lcdi_pkg::LCDI_EXEC;
                        cnt_q <= SHRT_N - 17'h1;
                    end
                    else if (dwr || drd)
                    begin
                        st_q  <= lcdi_pkg::LCDI_EXEC;
                        cnt_q <= DATA_N - 17'h1;
                    end
                end
                lcdi_pkg::LCDI_FILL:
                begin
                    // Fill runs inside the clear time
                    if (cnt_q != 17'h0)
                        cnt_q <= cnt_q - 17'h1;
                    fill_q <= fill_q + 7'h1;
                    if (fill_q == 7'(`LCDI_DRAM_DEPTH - 1))
                        st_q <= lcdi_pkg::LCDI_EXEC;
                end
                lcdi_pkg::LCDI_EXEC:
                begin
                    if (cnt_q == 17'h0)
                        st_q <= lcdi_pkg::LCDI_IDLE;
                    else
                        cnt_q <= cnt_q - 17'h1;
                end
            endcase
        end
    end

    // ****************************************
    // Address counter and display shift
    // ****************************************
    logic done;
    assign done = (st_q == lcdi_pkg::LCDI_EXEC) && (cnt_q == 17'h0);

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ac_q     <= 7'h0;
            shift_q  <= 7'h0;
            glyph_q  <= 1'b0;
            step_q   <= 1'b0;
            shpend_q <= 1'b0;
            stale_q  <= 1'b0;
        end
        else if (is_clr || is_home)
        begin
            ac_q    <= 7'h0;
            shift_q <= 7'h0;
            glyph_q <= 1'b0;
        end
        else if (is_cga)
        begin
            ac_q    <= {1'b0, byte_w[5:0]};
            glyph_q <= 1'b1;
            stale_q <= 1'b0;
        end
        else if (is_dda)
        begin
            ac_q    <= byte_w[6:0];
            glyph_q <= 1'b0;
            stale_q <= 1'b0;
        end
        else if (is_shf && !byte_w[`LCDI_B_SC])
        begin
            // Cursor move acts like an address load for reads
            ac_q    <= ac_step(ac_q, byte_w[`LCDI_B_RL], glyph_q, n_q);
            stale_q <= 1'b0;
        end
        else if (is_shf)
            shift_q <= sh_step(shift_q, !byte_w[`LCDI_B_RL], n_q);
        else if (dwr || drd)
        begin
            step_q   <= 1'b1;
            shpend_q <= dwr && sh_q && !glyph_q;
            stale_q  <= dwr ? 1'b1 : 1'b0;
        end
        else if (done && step_q)
        begin
            // Step lands only as busy drops
            ac_q     <= ac_step(ac_q, id_q, glyph_q, n_q);
            step_q   <= 1'b0;
            shpend_q <= 1'b0;
            if (shpend_q)
                shift_q <= sh_step(shift_q, id_q, n_q);
        end
    end

    // ****************************************
    // Mode latches
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            id_q <= `LCDI_RST_ID;
            sh_q <= `LCDI_RST_SH;
            dl_q <= `LCDI_RST_DL;
            n_q  <= `LCDI_RST_N;
            f_q  <= `LCDI_RST_F;
            {d_q, c_q, b_q} <= `LCDI_RST_DCB;
        end
        else if (is_clr)
            id_q <= 1'b1;
        else if (is_ent)
        begin
            id_q <= byte_w[`LCDI_B_ID];
            sh_q <= byte_w[`LCDI_B_SH];
        end
        else if (is_dsp)
        begin
            d_q <= byte_w[`LCDI_B_D];
            c_q <= byte_w[`LCDI_B_C];
            b_q <= byte_w[`LCDI_B_B];
        end
        else if (is_fun)
        begin
            dl_q <= byte_w[`LCDI_B_DL];
            n_q  <= byte_w[`LCDI_B_N];
            f_q  <= byte_w[`LCDI_B_F];
        end
    end

    // ****************************************
    // Blink timer
    // ****************************************
    // Free running so cursor and blink stay independent
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            bcnt_q <= 25'h0;
            bph_q  <= 1'b0;
        end
        else if (bcnt_q == 25'(BLINK_CYC - 1))
        begin
            bcnt_q <= 25'h0;
            bph_q  <= !bph_q;
        end
        else
            bcnt_q <= bcnt_q + 25'h1;
    end

    // ****************************************
    // Panel-facing outputs
    // ****************************************
    assign o_busy_indication = busy;
    assign o_display_on      = d_q;
    assign o_cursor_on       = c_q;
    assign o_blink_on        = b_q;
    assign o_blink_phase     = b_q && bph_q;
    assign o_cursor_row      = f_q ? `LCDI_ROW_LARGE : `LCDI_ROW_SMALL;
    assign o_cursor_addr     = ac_q;
    assign o_display_shift   = shift_q;
    assign o_two_line        = n_q;
    assign o_font_large      = f_q;
    assign o_data_length     = dl_q;
    assign o_glyph_sel       = glyph_q;

    // ****************************************
    // Checks
    // ****************************************
    // Busy length helper
    logic [16:0] blen_q, exp_q;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            blen_q <= 17'h0;
            exp_q  <= 17'h0;
        end
        else
        begin
            blen_q <= busy ? blen_q + 17'h1 : 17'h0;
            if (is_clr || is_home)
                exp_q <= CLR_N;
            else if (ins)
                exp_q <= SHRT_N;
            else if (dwr || drd)
                exp_q <= DATA_N;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    AST_BUSY_LEN: assert property ($fell(busy) |-> blen_q == exp_q)
        else $error("busy length differs from execution time");
    AST_CLEAR: assert property (is_clr |=> ac_q == 7'h0 && id_q && shift_q == 7'h0)
        else $error("clear left counter or direction wrong");
    AST_CLR_DIR: assert property (is_clr && !id_q |=> id_q)
        else $error("clear did not force increment");
    AST_HOME: assert property (is_home |=> ac_q == 7'h0 && shift_q == 7'h0)
        else $error("return home incomplete");
    AST_STATUS: assert property (i_rd_stb && !i_register_select && dl_q
                                 |=> o_rd_data == $past(stat_w))
        else $error("status read wrong");
    AST_AC_HOLD: assert property (busy && $past(busy) |-> $stable(ac_q))
        else $error("counter moved while busy");
    AST_STEP: assert property (done && step_q && !is_shf
                               |=> ac_q != $past(ac_q) && !busy)
        else $error("counter step missing at release");
    AST_READ_NOSHIFT: assert property (drd |=> !shpend_q ##1 $stable(shift_q))
        else $error("read scheduled a display shift");
    // First nibble must not execute and must be kept as the high half
    AST_NIBBLE: assert property (!dl_q && i_wr_stb && !nib_q
                                 |-> !wr_go ##1 (nib_q && hi_q == $past(i_wr_data[7:4])))
        else $error("half byte taken as whole or high nibble lost");
    AST_STALE: assert property (dwr |=> stale_q)
        else $error("write did not mark read stale");
    AST_BLINK: assert property (!b_q |-> !o_blink_phase)
        else $error("blink active while off");

    COV_CLEAR: cover property (is_clr ##1 busy [*3]);
    COV_SHIFT_WR: cover property (dwr && sh_q && !glyph_q);
    COV_NIB_RD: cover property (!dl_q && i_rd_stb ##1 i_rd_stb);

endmodule
`default_nettype wire

// ===== src/lcdi_defs.svh
`ifndef LCDI_DEFS_SVH
`define LCDI_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define LCDI_CLK_NS        20
`define LCDI_T_CLEAR_NS    1530000
`define LCDI_T_SHORT_NS    39000
`define LCDI_T_DATA_NS     43000
`define LCDI_T_BLINK_NS    400000000
// Least times round up
`define LCDI_CLEAR_CYC ((`LCDI_T_CLEAR_NS + `LCDI_CLK_NS - 1) / `LCDI_CLK_NS)
`define LCDI_SHORT_CYC ((`LCDI_T_SHORT_NS + `LCDI_CLK_NS - 1) / `LCDI_CLK_NS)
`define LCDI_DATA_CYC  ((`LCDI_T_DATA_NS + `LCDI_CLK_NS - 1) / `LCDI_CLK_NS)
`define LCDI_BLINK_CYC (`LCDI_T_BLINK_NS / `LCDI_CLK_NS)

// ****************************************
// Codes and address map
// ****************************************
`define LCDI_SPACE       8'h20
`define LCDI_DRAM_DEPTH  80
`define LCDI_CRAM_DEPTH  64
`define LCDI_LINE1_LAST  7'h27
`define LCDI_LINE2_BASE  7'h40
`define LCDI_LINE2_LAST  7'h67
`define LCDI_ONE_LAST    7'h4f
`define LCDI_LINE_LEN    7'h28
`define LCDI_ROW_SMALL   4'h7
`define LCDI_ROW_LARGE   4'ha

// ****************************************
// Field positions
// ****************************************
`define LCDI_B_ID  1
`define LCDI_B_SH  0
`define LCDI_B_D   2
`define LCDI_B_C   1
`define LCDI_B_B   0
`define LCDI_B_SC  3
`define LCDI_B_RL  2
`define LCDI_B_DL  4
`define LCDI_B_N   3
`define LCDI_B_F   2

// ****************************************
// Reset values
// ****************************************
`define LCDI_RST_DL  1'b1
`define LCDI_RST_N   1'b0
`define LCDI_RST_F   1'b0
`define LCDI_RST_ID  1'b1
`define LCDI_RST_SH  1'b0
`define LCDI_RST_DCB 3'h0

`endif

// ===== src/lcdi_pkg.sv
`default_nettype none
package lcdi_pkg;
    // Execution state, one-hot
    typedef enum logic [2:0] {
        LCDI_IDLE = 3'b001,
        LCDI_EXEC = 3'b010,
        LCDI_FILL = 3'b100
    } lcdi_state_e;
endpackage
`default_nettype wire

// ===== testbench/lcdi_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host processor on the instruction bus
// ****************************************
module lcdi_host (
    input  wire logic       i_clk,
    input  wire logic       i_busy_indication,
    output var  logic       o_register_select,
    output var  logic       o_wr_stb,
    output var  logic       o_rd_stb,
    output var  logic [7:0] o_wr_data
);
    logic [7:0] exp_q [$];  // Expected read answers, oldest first

    // Quiet bus from time zero
    initial
    begin
        o_register_select = 1'b0;
        o_wr_stb          = 1'b0;
        o_rd_stb          = 1'b0;
        o_wr_data         = 8'h00;
    end

    // One write cycle; data inverted after so a stale byte never matches
    task wr(input logic s, input logic [7:0] d);
        o_register_select <= s;
        o_wr_data         <= d;
        o_wr_stb          <= 1'b1;
        @(posedge i_clk);
        o_wr_stb  <= 1'b0;
        o_wr_data <= ~d;
    endtask

    // One read cycle; the answer is noted before the strobe goes out
    task rd(input logic s, input logic [7:0] e);
        exp_q.push_back(e);
        o_register_select <= s;
        o_rd_stb          <= 1'b1;
        @(posedge i_clk);
        o_rd_stb <= 1'b0;
    endtask

    // Four-bit write: high nibble, then low nibble on the next edge.
    // Low lines carry the other nibble so that any use of them shows.
    task wr2(input logic s, input logic [7:0] d);
        o_register_select <= s;
        o_wr_data         <= d;
        o_wr_stb          <= 1'b1;
        @(posedge i_clk);
        o_wr_data <= {d[3:0], d[7:4]};
        @(posedge i_clk);
        o_wr_stb  <= 1'b0;
        o_wr_data <= ~d;
    endtask

    // Four-bit read: two strobes, high nibble answer first
    task rd2(input logic s, input logic [7:0] e);
        exp_q.push_back({e[7:4], 4'h0});
        exp_q.push_back({e[3:0], 4'h0});
        o_register_select <= s;
        o_rd_stb          <= 1'b1;
        @(posedge i_clk);
        @(posedge i_clk);
        o_rd_stb <= 1'b0;
    endtask

    // Poll busy before the next request; bounded so a stuck flag ends
    task idle(output int n);
        @(posedge i_clk);
        for (n = 0; n < 80000 && i_busy_indication === 1'b1; n++)
            @(posedge i_clk);
    endtask
endmodule

`default_nettype wire

// ===== testbench/tb_char_lcd_instruction_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module tb_char_lcd_instruction_decoder;
    logic        clk, rst, rs, wr, rd, busy, don, con, bon, two, fl, dl, gs, bph;
    logic        rd_q = 1'b0;  // Read taken at the last edge
    logic [7:0]  wd, rdat, b, c, p;  // p: oldest expected read answer
    logic [3:0]  row;
    logic [6:0]  ac, sh;
    int          mismatches = 0, checked = 0, cyc = 0, n;
    logic [13:0] tab [4] = '{{7'h0f, 7'h00}, {7'h10, 7'h00}, {7'h10, 7'h01}, {7'h10, 7'h00}};

    lcdi_host lcdi_host_i (.i_clk(clk), .i_busy_indication(busy), .o_register_select(rs),
        .o_wr_stb(wr), .o_rd_stb(rd), .o_wr_data(wd));

    // Short clear time keeps the run brief
    lcdi_decoder #(.CLEAR_CYC(100), .BLINK_CYC(8)) lcdi_decoder_i (.i_clk(clk),
        .i_reset(rst), .i_register_select(rs), .i_wr_stb(wr), .i_rd_stb(rd),
        .i_wr_data(wd), .o_rd_data(rdat), .o_busy_indication(busy), .o_display_on(don),
        .o_cursor_on(con), .o_blink_on(bon), .o_blink_phase(bph), .o_cursor_row(row),
        .o_cursor_addr(ac), .o_display_shift(sh), .o_two_line(two), .o_font_large(fl),
        .o_data_length(dl), .o_glyph_sel(gs));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Read answer is valid from the cycle after the strobe, so compare it there; also the hang limit
    always @(posedge clk)
    begin
        if (rd_q === 1'b1)
        begin
            p = lcdi_host_i.exp_q.pop_front();
            `CHK(rdat, p)
        end
        rd_q <= rd;
        cyc  <= cyc + 1;
        if (cyc == 100000)
        begin
            mismatches++;
            test_done();
        end
    end

    task test_done;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Write then measure the busy span
    task cmd(input logic s, input logic [7:0] d, input int e);
        lcdi_host_i.wr(s, d);
        lcdi_host_i.idle(n);
        `CHK(n, e)
    endtask

    // Read; data reads also measure the busy span
    task get(input logic s, input logic [7:0] e, input int t);
        lcdi_host_i.rd(s, e);
        if (t > 0)
        begin
            lcdi_host_i.idle(n);
            `CHK(n, t)
        end
    endtask

    // Four-bit write then measure the busy span
    task cmd4(input logic s, input logic [7:0] d, input int e);
        lcdi_host_i.wr2(s, d);
        lcdi_host_i.idle(n);
        `CHK(n, e)
    endtask

    // Four-bit read; the span is counted from after the second strobe
    task get4(input logic s, input logic [7:0] e, input int t);
        lcdi_host_i.rd2(s, e);
        if (t > 0)
        begin
            lcdi_host_i.idle(n);
            `CHK(n, t)
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        b = 8'($urandom(99068));
        c = 8'($urandom);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        `CHK({dl, two, fl, don, gs}, 5'b10000)
        get(0, 8'h00, 0);
        cmd(0, 8'h01, 100);
        cmd(0, 8'h85, 1950);
        get(0, 8'h05, 0);
        cmd(0, 8'h07, 1950);
        lcdi_host_i.wr(1, b);
        get(0, 8'h85, 0);
        lcdi_host_i.idle(n);
        `CHK(n, 2149)
        `CHK({ac, sh}, {7'h06, 7'h01})
        cmd(0, 8'h85, 1950);
        get(1, b, 2150);
        `CHK({ac, sh}, {7'h06, 7'h01})
        cmd(0, 8'h05, 1950);
        cmd(1, ~b, 2150);
        `CHK({ac, sh}, {7'h05, 7'h00})
        cmd(0, 8'h7f, 1950);
        `CHK({gs, ac}, {1'b1, 7'h3f})
        cmd(1, c, 2150);
        `CHK({ac, sh}, {7'h3e, 7'h00})
        cmd(0, 8'h7f, 1950);
        get(1, c, 2150);
        cmd(0, 8'h90, 1950);
        for (int i = 0; i < 4; i++)
        begin
            cmd(0, 8'(16 + 4 * i), 1950);
            `CHK({ac, sh}, tab[i])
        end
        for (int i = 0; i < 8; i++)
        begin
            cmd(0, 8'(8 + i), 1950);
            `CHK({don, con, bon}, 3'(i))
        end
        // Blink on: phase is high for half of any 16-cycle window
        n = 0;
        repeat (16)
        begin
            @(posedge clk);
            n += int'(bph);
        end
        `CHK(n, 8)
        cmd(0, 8'h3c, 1950);
        `CHK({dl, two, fl, row}, {3'b111, 4'ha})
        cmd(0, 8'h30, 1950);
        `CHK({dl, two, fl, row}, {3'b100, 4'h7})
        cmd(0, 8'h18, 1950);
        cmd(0, 8'h02, 100);
        `CHK({ac, sh}, {7'h00, 7'h00})
        cmd(0, 8'h85, 1950);
        get(1, b, 2150);
        cmd(0, 8'h01, 100);
        cmd(0, 8'h85, 1950);
        get(1, 8'h20, 2150);
        `CHK(ac, 7'h06)
        // Four-bit transfers, two-line map and the stale first read
        cmd(0, 8'h28, 1950);
        `CHK({dl, two}, 2'b01)
        cmd4(0, 8'h06, 1950);
        cmd4(0, 8'hc0, 1950);
        cmd4(1, c | 8'h80, 2150);
        cmd4(0, 8'ha7, 1950);
        cmd4(1, ~c, 2150);
        `CHK(ac, 7'h40)
        get4(1, 8'h20, 2149);
        cmd4(0, 8'h10, 1950);
        get4(1, c | 8'h80, 2149);
        get4(0, 8'h41, 0);
        repeat (2) @(posedge clk);
        test_done();
    end
endmodule

`default_nettype wire
